/* src/rivm_vector_map.sv */
// Reset and interrupt vector address map facing the core fetch logic
`timescale 1ns/1ns
`default_nettype none
// Function
// [R1] Vector spacing one word small, two large
// [R2] No boot section: vectors never relocate
// [R3] Boot variants: reset location from fuse
// [R4] Boot variants: vector base from relocate bit
// [R5] Any reset starts at vector one
// [R6] External requests zero, one at 0x001, 0x002
// [R7] Pin-change groups 0x003-0x005, watchdog 0x006
// [R8] Second 8-bit timer at 0x007-0x009
// [R9] 16-bit timer at 0x00A-0x00D
// [R10] First 8-bit timer at 0x00E-0x010
// [R11] SPI 0x011, USART 0x012-0x014
// [R12] ADC, nv memory, comparator 0x015-0x017
// [R13] Two-wire 0x018, store ready 0x019 last
// [R14] Relocated vector adds boot start address
// [R15] Programmed fuse puts reset at boot
// [R16] Lowest pending vector number served first
module rivm_vector_map
  import rivm_pkg::*;
#(
  parameter logic               HAS_BOOT   = 1'b0,
  parameter int                 VEC_WORDS  = RIVM_SPACE_SMALL,
  parameter logic [RIVM_AW-1:0] BOOT_START = RIVM_BOOT_START_DEF
)
(
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire logic [RIVM_NUM_IRQ-1:0] irq_req,
  input  wire logic                    boot_reset_select_fuse,
  input  wire logic                    vector_relocate_bit,
  input  wire logic                    vector_taken,
  output logic                         vec_valid_q,
  output logic [RIVM_NUM_W-1:0]        vec_num_q,
  output logic [RIVM_AW-1:0]           vec_addr_q,
  output logic [RIVM_NUM_IRQ-1:0]      irq_ack_q
);

  function automatic logic [RIVM_AW-1:0] tab_addr(input logic [RIVM_NUM_W-1:0] num);
    logic [RIVM_NUM_W-1:0] pos;
    pos = num - RIVM_VEC_RESET;
    return RIVM_AW'(RIVM_TAB_ADDR[pos] * VEC_WORDS); // R1
  endfunction

  logic                      strap_done_q;
  logic                      fuse_prog_q;
  logic                      reset_pend_q;
  logic                      vec_valid_d;
  logic [RIVM_NUM_W-1:0]     vec_num_d;
  logic [RIVM_AW-1:0]        vec_addr_d;
  logic [RIVM_NUM_IRQ-1:0]   irq_ack_d;

  wire                       take;
  wire                       irq_any;
  wire [RIVM_NUM_W-1:0]      irq_idx;
  wire [RIVM_NUM_IRQ-1:0]    req_eff;
  wire                       reloc;
  wire [RIVM_AW-1:0]         vec_base;
  wire [RIVM_AW-1:0]         reset_addr;
  wire [RIVM_NUM_W-1:0]      irq_num;

  assign take     = vec_valid_q & vector_taken;
  // Acked source is masked one cycle while its flag is being cleared
  assign req_eff  = irq_req & ~irq_ack_q;
  assign irq_num  = irq_idx + RIVM_IRQ_NUM_OFS;

  rivm_prio_enc u_prio (
    .req (req_eff),
    .any (irq_any),
    .idx (irq_idx)
  ); // R16

  assign reloc      = HAS_BOOT & vector_relocate_bit; // R2 R4
  assign vec_base   = reloc ? BOOT_START : RIVM_RESET_ADDR; // R14
  assign reset_addr = (HAS_BOOT & fuse_prog_q) ? BOOT_START : RIVM_RESET_ADDR; // R15

  // Drops for one cycle after each take so the core sees a fresh vector
  assign vec_valid_d = ~take & strap_done_q & (reset_pend_q | irq_any);
  assign vec_num_d   = reset_pend_q ? RIVM_VEC_RESET : irq_num; // R5 R16
  assign vec_addr_d  = reset_pend_q ? reset_addr : vec_base + tab_addr(irq_num); // R6 R7 R8 R9 R10 R11 R12 R13

  genvar gi;
  generate
    for (gi = 0; gi < RIVM_NUM_IRQ; gi++) begin : g_ack
      assign irq_ack_d[gi] = take & (vec_num_q == RIVM_NUM_W'(gi) + RIVM_IRQ_NUM_OFS);
    end
  endgenerate

  // Fuse caught once after reset release, never under the async reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_done_q <= 1'b0;
      fuse_prog_q  <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      fuse_prog_q  <= (boot_reset_select_fuse == RIVM_FUSE_PROG); // R3
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_pend_q <= 1'b1; // R5
    end else if (take && vec_num_q == RIVM_VEC_RESET) begin
      reset_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vec_valid_q <= 1'b0;
      vec_num_q   <= RIVM_VEC_RESET;
      vec_addr_q  <= RIVM_RESET_ADDR;
      irq_ack_q   <= '0;
    end else begin
      vec_valid_q <= vec_valid_d;
      vec_num_q   <= vec_num_d;
      vec_addr_q  <= vec_addr_d;
      irq_ack_q   <= irq_ack_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_reset_first;
    $rose(strap_done_q) |=> vec_valid_q && vec_num_q == RIVM_VEC_RESET;
  endproperty
  a_reset_first: assert property (p_reset_first) // R5
    else $error("reset vector not offered first");

  property p_reset_addr;
    vec_valid_q && vec_num_q == RIVM_VEC_RESET |->
      vec_addr_q == ((HAS_BOOT && fuse_prog_q) ? BOOT_START : RIVM_RESET_ADDR);
  endproperty
  a_reset_addr: assert property (p_reset_addr) // R15
    else $error("reset vector address wrong for fuse setting");

  property p_fuse_catch;
    $rose(strap_done_q) |-> fuse_prog_q == ($past(boot_reset_select_fuse) == RIVM_FUSE_PROG);
  endproperty
  a_fuse_catch: assert property (p_fuse_catch) // R3
    else $error("boot reset fuse not captured");

  property p_no_boot;
    !HAS_BOOT && vec_valid_q |-> vec_addr_q <= tab_addr(RIVM_VEC_LAST);
  endproperty
  a_no_boot: assert property (p_no_boot) // R2
    else $error("vector relocated in variant without boot section");

  property p_spacing;
    vec_valid_q && vec_num_q != RIVM_VEC_RESET && !$past(take) && !$past(reloc) |->
      vec_addr_q == RIVM_AW'((vec_num_q - RIVM_VEC_RESET) * VEC_WORDS);
  endproperty
  a_spacing: assert property (p_spacing) // R1
    else $error("vector spacing wrong");

  property p_reloc;
    vec_valid_q && vec_num_q != RIVM_VEC_RESET && !$past(take) && $past(reloc) |->
      vec_addr_q == BOOT_START + tab_addr(vec_num_q);
  endproperty
  a_reloc: assert property (p_reloc) // R14
    else $error("relocated vector not offset by boot start");

  property p_base_sel;
    HAS_BOOT && vec_valid_q && vec_num_q != RIVM_VEC_RESET && !$past(take) |->
      (vec_addr_q >= BOOT_START) == $past(vector_relocate_bit);
  endproperty
  a_base_sel: assert property (p_base_sel) // R4
    else $error("vector base does not follow relocate bit");

  property p_prio;
    vec_valid_q && vec_num_q != RIVM_VEC_RESET && !$past(take) |->
      ($past(req_eff) & ((25'h000_0001 << (vec_num_q - RIVM_IRQ_NUM_OFS)) - 25'h000_0001))
        == 25'h000_0000;
  endproperty
  a_prio: assert property (p_prio) // R16
    else $error("higher priority request skipped");

  property p_ack;
    take && vec_num_q != RIVM_VEC_RESET |=>
      irq_ack_q == (25'h000_0001 << ($past(vec_num_q) - RIVM_IRQ_NUM_OFS)) && !vec_valid_q;
  endproperty
  a_ack: assert property (p_ack) // R16
    else $error("serviced source not acknowledged");

  property p_num_range;
    vec_valid_q |-> vec_num_q >= RIVM_VEC_RESET && vec_num_q <= RIVM_VEC_LAST;
  endproperty
  a_num_range: assert property (p_num_range) // R13
    else $error("vector number outside table");

  property p_table;
    vec_valid_q && vec_num_q != RIVM_VEC_RESET && !$past(reloc) |->
      vec_addr_q == RIVM_AW'(RIVM_TAB_ADDR[vec_num_q - RIVM_VEC_RESET] * VEC_WORDS);
  endproperty
  a_table: assert property (p_table) // R6 R7 R8 R9 R10 R11 R12 R13
    else $error("vector address differs from table");

  property p_reset_gap;
    take && vec_num_q == RIVM_VEC_RESET |=> !vec_valid_q && irq_ack_q == '0;
  endproperty
  a_reset_gap: assert property (p_reset_gap) // R5
    else $error("reset take acknowledged a source");

  property p_reset_hold;
    reset_pend_q && vec_valid_q |-> vec_num_q == RIVM_VEC_RESET;
  endproperty
  a_reset_hold: assert property (p_reset_hold) // R5
    else $error("interrupt offered before reset vector");

  property p_ack_onehot;
    irq_ack_q != '0 |-> $onehot(irq_ack_q) && $past(take);
  endproperty
  a_ack_onehot: assert property (p_ack_onehot) // R16
    else $error("acknowledge not a single pulse after take");

  property p_idle;
    !reset_pend_q && $past(req_eff) == '0 |-> !vec_valid_q;
  endproperty
  a_idle: assert property (p_idle) // R16
    else $error("vector offered with nothing pending");

  property p_small_fixed;
    !HAS_BOOT && vec_valid_q && vec_num_q == RIVM_VEC_RESET |-> vec_addr_q == RIVM_RESET_ADDR;
  endproperty
  a_small_fixed: assert property (p_small_fixed) // R2
    else $error("small variant reset address moved");

endmodule // rivm_vector_map
`default_nettype wire

/* src/rivm_pkg.sv */
// Constants shared by the reset and interrupt vector map
package rivm_pkg;

  localparam int RIVM_AW     = 14;
  localparam int RIVM_NUM_W  = 5;
  localparam int RIVM_NUM_IRQ = 25;
  localparam int RIVM_NUM_VEC = 26;

  // Vector numbers are 1-based; the reset vector is number 1
  localparam logic [RIVM_NUM_W-1:0] RIVM_VEC_RESET   = 5'h01;
  localparam logic [RIVM_NUM_W-1:0] RIVM_IRQ_NUM_OFS = 5'h02;
  localparam logic [RIVM_NUM_W-1:0] RIVM_VEC_LAST    = 5'h1a;

  localparam logic [RIVM_AW-1:0] RIVM_RESET_ADDR = 14'h0000;

  // Table addresses in one-word units, indexed by vector number minus one
  localparam logic [RIVM_AW-1:0] RIVM_TAB_ADDR [0:RIVM_NUM_VEC-1] = '{
    14'h0000,                                  // reset
    14'h0001, 14'h0002,                        // external requests
    14'h0003, 14'h0004, 14'h0005, 14'h0006,    // pin change groups, watchdog
    14'h0007, 14'h0008, 14'h0009,              // second 8-bit timer
    14'h000a, 14'h000b, 14'h000c, 14'h000d,    // 16-bit timer
    14'h000e, 14'h000f, 14'h0010,              // first 8-bit timer
    14'h0011, 14'h0012, 14'h0013, 14'h0014,    // SPI, USART
    14'h0015, 14'h0016, 14'h0017,              // ADC, nv data ready, comparator
    14'h0018, 14'h0019                         // two-wire, store ready
  };

  // Vector spacing in instruction words per variant class
  localparam int RIVM_SPACE_SMALL = 1;
  localparam int RIVM_SPACE_LARGE = 2;

  // Fuse level meaning programmed
  localparam logic RIVM_FUSE_PROG = 1'b0;

  localparam logic [RIVM_AW-1:0] RIVM_BOOT_START_DEF = 14'h0c00;

endpackage

/* src/rivm_prio_enc.sv */
// Lowest-index-first priority encoder over pending requests
`timescale 1ns/1ns
`default_nettype none
module rivm_prio_enc
  import rivm_pkg::*;
(
  input  wire logic [RIVM_NUM_IRQ-1:0] req,
  output logic                         any,
  output logic [RIVM_NUM_W-1:0]        idx
);

  always_comb begin
    any = 1'b0;
    idx = '0;
    // Descending scan so the lowest set index wins
    for (int i = RIVM_NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = RIVM_NUM_W'(i);
      end
    end
  end

endmodule // rivm_prio_enc
`default_nettype wire

/* sim/rivm_core_model.sv */
// Core fetch model that takes each offered vector
`timescale 1ns/1ns
`default_nettype none
module rivm_core_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic vec_valid_q,
  input  wire logic slow,
  output var logic  vector_taken
);
  logic held_q;
  // Slow mode leaves an offer waiting one extra cycle
  initial begin
    held_q = 1'b0;
    vector_taken = 1'b0;
    forever begin
      @(posedge clk);
      #1;
      held_q = vec_valid_q && slow && !held_q && !vector_taken;
      vector_taken = reset_n && vec_valid_q && !vector_taken && !held_q;
    end
  end
endmodule // rivm_core_model
`default_nettype wire

/* sim/reset_interrupt_vector_map_test.sv */
// Self-checking bench for the vector map, small and boot variants
`timescale 1ns/1ns
`default_nettype none
module reset_interrupt_vector_map_test;
  import rivm_pkg::*;
  logic                    clk = 1'b0;
  logic                    reset_n = 1'b0;
  logic                    fuse = 1'b1;
  logic                    reloc = 1'b0;
  logic                    slow = 1'b0;
  logic                    taken;
  logic [RIVM_NUM_IRQ-1:0] irq_req = '0;
  logic [RIVM_NUM_IRQ-1:0] mask;
  logic                    v_a;
  logic [RIVM_NUM_W-1:0]   n_a;
  logic [RIVM_AW-1:0]      a_a;
  logic [RIVM_AW-1:0]      a_b;
  logic [RIVM_NUM_IRQ-1:0] k_a;
  logic                    v_b;
  logic [RIVM_NUM_W-1:0]   n_b;
  logic [RIVM_NUM_IRQ-1:0] k_b;
  logic [4:0]              e;
  logic [4:0]              last_num;
  logic [4:0]              q[$];
  logic [31:0]             seed = 32'h0000_0046;
  int                      num_errors = 0;
  int                      comparisons = 0;
  int                      cycles = 0;

  always #20 clk = ~clk;

  rivm_vector_map uut (.clk, .reset_n, .irq_req, .boot_reset_select_fuse(fuse),
    .vector_relocate_bit(reloc), .vector_taken(taken), .vec_valid_q(v_a),
    .vec_num_q(n_a), .vec_addr_q(a_a), .irq_ack_q(k_a));
  rivm_vector_map #(.HAS_BOOT(1'b1), .VEC_WORDS(2), .BOOT_START(RIVM_BOOT_START_DEF)) uut_boot (
    .clk, .reset_n, .irq_req, .boot_reset_select_fuse(fuse), .vector_relocate_bit(reloc),
    .vector_taken(taken), .vec_valid_q(v_b), .vec_num_q(n_b),
    .vec_addr_q(a_b), .irq_ack_q(k_b));
  rivm_core_model core (.clk, .reset_n, .vec_valid_q(v_a), .slow, .vector_taken(taken));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic idle;
    for (int i = 0; i < 200 && (q.size() != 0 || irq_req !== '0); i++) begin
      @(posedge clk);
      #1;
      // Peripheral side drops its request once the ack is seen
      irq_req = irq_req & ~k_a;
    end
    repeat (3) @(posedge clk);
    #1;
    check(q.size(), 0);
    check(irq_req, 32'h0000_0000);
  endtask

  // Whole run needs about 450 cycles; ceiling leaves ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      complete_run();
    end
  end

  // Both variants must acknowledge and offer the same sources
  always @(posedge clk) begin
    if (k_a !== '0 || k_b !== '0) begin
      check(k_a, 32'h0000_0001 << (last_num - 5'h02));
      check(k_b, 32'h0000_0001 << (last_num - 5'h02));
    end
    if (taken && v_a) begin
      e = (q.size() != 0) ? q.pop_front() : 5'h00;
      last_num = e;
      check(n_a, e);
      check(n_b, e);
      check(v_b, 32'h0000_0001);
      check(a_a, e - 32'h0000_0001);
      check(a_b, (e == 5'h01) ? (fuse == RIVM_FUSE_PROG ? RIVM_BOOT_START_DEF : 14'h0000)
        : (reloc ? RIVM_BOOT_START_DEF : 14'h0000) + 32'h0000_0002 * (e - 5'h01));
    end
  end

  initial begin
    q.push_back(5'h01);
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    idle();
    for (int k = 2; k <= 26; k++) begin
      seed = xs(seed);
      slow = seed[0];
      reloc = seed[1];
      q.push_back(5'(k));
      irq_req[k-2] = 1'b1;
      idle();
    end
    // Several pending at once must come out lowest number first
    for (int r = 0; r < 8; r++) begin
      seed = xs(seed);
      slow = seed[31];
      reloc = seed[30];
      mask = seed[24:0];
      for (int b = 0; b < 25; b++) if (mask[b]) q.push_back(5'(b + 2));
      irq_req = mask;
      idle();
    end
    // Second reset with the fuse programmed and the last source pending
    reset_n = 1'b0;
    fuse = RIVM_FUSE_PROG;
    irq_req = 25'h100_0000;
    q.push_back(5'h01);
    q.push_back(5'h1a);
    repeat (3) @(posedge clk);
    #1 reset_n = 1'b1;
    idle();
    complete_run();
  end
endmodule // reset_interrupt_vector_map_test
`default_nettype wire
